//--- rtl/power_cfg_pkg.sv
package power_cfg_pkg;

    localparam int NUM_REGS = 9;
    localparam int IDX_W    = 4;
    localparam int DATA_W   = 16;

    // command codes of the bank
    localparam logic [7:0] CODE_MOD_CFG     = 8'he3;
    localparam logic [7:0] CODE_DROOP_TRIM  = 8'he4;
    localparam logic [7:0] CODE_READBACK    = 8'he5;
    localparam logic [7:0] CODE_BOOT        = 8'he6;
    localparam logic [7:0] CODE_RSVD        = 8'he7;
    localparam logic [7:0] CODE_TLIM_ISCALE = 8'he8;
    localparam logic [7:0] CODE_TCOMP_ADD   = 8'he9;
    localparam logic [7:0] CODE_FULL_SCALE  = 8'hea;
    localparam logic [7:0] CODE_SPEEDUP     = 8'hf3;
    localparam logic [7:0] CODE_VID_SETTING = 8'hd0;

    // storage index of each register
    localparam logic [IDX_W-1:0] IDX_MOD_CFG     = 4'h0;
    localparam logic [IDX_W-1:0] IDX_DROOP_TRIM  = 4'h1;
    localparam logic [IDX_W-1:0] IDX_READBACK    = 4'h2;
    localparam logic [IDX_W-1:0] IDX_BOOT        = 4'h3;
    localparam logic [IDX_W-1:0] IDX_RSVD        = 4'h4;
    localparam logic [IDX_W-1:0] IDX_TLIM_ISCALE = 4'h5;
    localparam logic [IDX_W-1:0] IDX_TCOMP_ADD   = 4'h6;
    localparam logic [IDX_W-1:0] IDX_FULL_SCALE  = 4'h7;
    localparam logic [IDX_W-1:0] IDX_SPEEDUP     = 4'h8;
    localparam logic [IDX_W-1:0] IDX_LAST        = 4'h8;

    // implemented bits of each register, by index
    localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
        16'h3fff, 16'h03ff, 16'h01ff, 16'h00ff, 16'h00ff,
        16'h007f, 16'h003f, 16'h00ff, 16'h01ff};

    localparam logic [DATA_W-1:0] REG_RESET     = 16'h0000;
    localparam logic [7:0]        VID_RESET     = 8'h00;
    localparam int                HF_GAIN_BIT   = 13;
    localparam int                K_DISC_BIT    = 8;
    localparam logic [11:0]       BOOT_BASE_10  = 12'h1f4;
    localparam logic [11:0]       BOOT_BASE_5   = 12'h0fa;
    localparam logic [11:0]       BOOT_STEP_10  = 12'h00a;
    localparam logic [11:0]       BOOT_STEP_5   = 12'h005;
    localparam logic [7:0]        DBAND_STEP_MV = 8'h19;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_RUN  = 2'b01,
        LD_LAST = 2'b11
    } load_state_e;

    function automatic logic signed [3:0] sext3(input logic [2:0] code);
        return {code[2], code};
    endfunction

    function automatic logic [6:0] tmax_decode(input logic [2:0] code);
        case (code)
            3'h0:    return 7'h64;
            3'h1:    return 7'h69;
            3'h2:    return 7'h6e;
            3'h3:    return 7'h73;
            3'h4:    return 7'h78;
            3'h5:    return 7'h55;
            3'h6:    return 7'h5a;
            default: return 7'h5f;
        endcase
    endfunction

    // {valid, index}; host-visible codes only
    function automatic logic [IDX_W:0] code_index(input logic [7:0] code);
        case (code)
            CODE_MOD_CFG:     return {1'b1, IDX_MOD_CFG};
            CODE_DROOP_TRIM:  return {1'b1, IDX_DROOP_TRIM};
            CODE_READBACK:    return {1'b1, IDX_READBACK};
            CODE_BOOT:        return {1'b1, IDX_BOOT};
            CODE_RSVD:        return {1'b1, IDX_RSVD};
            CODE_TLIM_ISCALE: return {1'b1, IDX_TLIM_ISCALE};
            CODE_TCOMP_ADD:   return {1'b1, IDX_TCOMP_ADD};
            CODE_FULL_SCALE:  return {1'b1, IDX_FULL_SCALE};
            CODE_SPEEDUP:     return {1'b1, IDX_SPEEDUP};
            default:          return 5'h00;
        endcase
    endfunction

endpackage

//--- rtl/nvm_load_if.sv
interface nvm_load_if;
    logic                             start;
    logic                             busy;
    logic                             wr_valid;
    logic [power_cfg_pkg::IDX_W-1:0] wr_index;
    logic [power_cfg_pkg::IDX_W-1:0] rd_index;

    modport loader (input start, output busy, output wr_valid, output wr_index, output rd_index);
    modport bank   (output start, input busy, input wr_valid, input wr_index, input rd_index);
endinterface

//--- rtl/nvm_bank_loader.sv
module nvm_bank_loader (
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    nvm_load_if.loader ld
);
    power_cfg_pkg::load_state_e state_r;
    power_cfg_pkg::load_state_e state_nxt;
    logic                       powerup_r;
    logic                       busy_r;
    logic                       wr_valid_r;
    logic [power_cfg_pkg::IDX_W-1:0] rd_index_r;
    logic [power_cfg_pkg::IDX_W-1:0] wr_index_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            power_cfg_pkg::LD_IDLE: if (ld.start || powerup_r) state_nxt = power_cfg_pkg::LD_RUN;
            power_cfg_pkg::LD_RUN:  if (rd_index_r == power_cfg_pkg::IDX_LAST) state_nxt = power_cfg_pkg::LD_LAST;
            power_cfg_pkg::LD_LAST: state_nxt = power_cfg_pkg::LD_IDLE;
            default:                state_nxt = power_cfg_pkg::LD_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= power_cfg_pkg::LD_IDLE;
            busy_r  <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            busy_r  <= (state_nxt != power_cfg_pkg::LD_IDLE);
        end
    end

    // the first load after power-up needs no request from outside
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in)
            powerup_r <= 1'b1;
        else if (ce_in && state_r == power_cfg_pkg::LD_IDLE)
            powerup_r <= 1'b0;
    end

    // nvm word appears one cycle after its index
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_index_r <= '0;
            wr_index_r <= '0;
            wr_valid_r <= 1'b0;
        end else if (ce_in) begin
            rd_index_r <= (state_r == power_cfg_pkg::LD_RUN && rd_index_r != power_cfg_pkg::IDX_LAST)
                        ? rd_index_r + 4'h1 : 4'h0;
            wr_index_r <= rd_index_r;
            wr_valid_r <= (state_r == power_cfg_pkg::LD_RUN);
        end
    end

    assign ld.busy     = busy_r;
    assign ld.wr_valid = wr_valid_r;
    assign ld.wr_index = wr_index_r;
    assign ld.rd_index = rd_index_r;
endmodule

//--- rtl/power_config_register_bank.sv
module power_config_register_bank #(
    parameter int ADC_W = 10
) (
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      ce_in,
    input  wire logic [7:0]                host_cmd_in,
    input  wire logic                      host_wr_in,
    input  wire logic                      host_rd_in,
    input  wire logic [15:0]               host_wdata_in,
    output logic      [15:0]               host_rdata_out,
    output logic                           host_ack_out,
    output logic                           host_err_out,
    input  wire logic                      reload_in,
    input  wire logic [15:0]               nvm_data_in,
    output logic      [3:0]                nvm_index_out,
    output logic                           load_busy_out,
    input  wire logic [7:0]                boot_strap_code_in,
    input  wire logic                      vid_res_5mv_in,
    input  wire logic [2:0]                phase_count_in,
    input  wire logic                      disc_conduction_in,
    input  wire logic [ADC_W-1:0]          monitor_level_in,
    input  wire logic [7:0]                temp_c_in,
    output logic                           hf_gain_x2_out,
    output logic signed [5:0]              noload_trim_q_out,
    output logic signed [3:0]              readback_ofs_out,
    output logic      [7:0]                iout_reading_out,
    output logic      [11:0]               boot_mv_out,
    output logic      [4:0]                iin_full_scale_a_out,
    output logic                           tcomp_enable_out,
    output logic signed [9:0]              tcomp_offset_dc_out,
    output logic                           thermal_phase_add_out,
    output logic                           freq_limiter_en_out,
    output logic      [4:0]                speedup_pf_out,
    output logic      [7:0]                deadband_mv_out,
    output logic      [1:0]                k_factor_q_out,
    output logic                           k_active_out
);

    ////////////////////////////////////////////////////////////////////////
    // storage and nvm loading

    logic [15:0]       mem_r [power_cfg_pkg::NUM_REGS];
    logic [7:0]        vid_setting_r;
    logic              strap_taken_r;
    logic [4:0]        host_hit;
    logic              host_wr_ok;
    logic              host_write_busy;

    nvm_load_if ld ();

    nvm_bank_loader u_loader (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .ld       (ld)
    );

    assign ld.start        = reload_in;
    assign nvm_index_out   = ld.rd_index;
    assign load_busy_out   = ld.busy;
    assign host_hit        = power_cfg_pkg::code_index(host_cmd_in);
    assign host_write_busy = host_wr_in && ld.busy;
    assign host_wr_ok      = host_wr_in && host_hit[4] && !ld.busy;

    // loader owns the bank while busy; host writes then are refused
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < power_cfg_pkg::NUM_REGS; i++)
                mem_r[i] <= power_cfg_pkg::REG_RESET;
        end else if (ce_in) begin
            if (ld.wr_valid)
                mem_r[ld.wr_index] <= nvm_data_in & power_cfg_pkg::REG_MASK[ld.wr_index];
            else if (host_wr_ok)
                mem_r[host_hit[3:0]] <= host_wdata_in & power_cfg_pkg::REG_MASK[host_hit[3:0]];
        end
    end

    // strap is caught once after reset release, in its own register only
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vid_setting_r <= power_cfg_pkg::VID_RESET;
            strap_taken_r <= 1'b0;
        end else if (ce_in && !strap_taken_r) begin
            vid_setting_r <= boot_strap_code_in;
            strap_taken_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host command answers, one cycle after the strobe

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            host_rdata_out <= 16'h0000;
            host_ack_out   <= 1'b0;
            host_err_out   <= 1'b0;
        end else if (ce_in) begin
            host_ack_out <= 1'b0;
            host_err_out <= 1'b0;
            if (host_rd_in) begin
                if (host_cmd_in == power_cfg_pkg::CODE_VID_SETTING) begin
                    host_rdata_out <= {8'h00, vid_setting_r};
                    host_ack_out   <= 1'b1;
                end else if (host_hit[4]) begin
                    host_rdata_out <= mem_r[host_hit[3:0]];
                    host_ack_out   <= 1'b1;
                end else begin
                    host_rdata_out <= 16'h0000;
                    host_err_out   <= 1'b1;
                end
            end else if (host_wr_in) begin
                host_ack_out <= host_wr_ok;
                host_err_out <= !host_wr_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode

    logic [2:0]          ofs_field;
    logic [ADC_W+7:0]    iout_prod;
    logic signed [9:0]   iout_sum;
    logic [7:0]          boot_code;
    logic [14:0]         temp_x100;
    logic [14:0]         add_limit;
    logic [6:0]          add_pct;

    always_comb begin
        case (phase_count_in)
            3'h1:    ofs_field = mem_r[power_cfg_pkg::IDX_READBACK][2:0];
            3'h2:    ofs_field = mem_r[power_cfg_pkg::IDX_READBACK][5:3];
            default: ofs_field = mem_r[power_cfg_pkg::IDX_READBACK][8:6];
        endcase
        case (mem_r[power_cfg_pkg::IDX_TCOMP_ADD][5:4])
            2'h0:    add_pct = 7'h4b;
            2'h1:    add_pct = 7'h52;
            2'h2:    add_pct = 7'h5b;
            default: add_pct = 7'h64;
        endcase
    end

    // full monitor range is 2^ADC_W codes, so the shift stands in for /2.5 V
    assign iout_prod = (ADC_W+8)'(monitor_level_in) * (ADC_W+8)'(mem_r[power_cfg_pkg::IDX_FULL_SCALE][7:0]);
    assign iout_sum  = $signed({2'b00, iout_prod[ADC_W+7:ADC_W]})
                     + 10'(power_cfg_pkg::sext3(ofs_field));
    assign boot_code = mem_r[power_cfg_pkg::IDX_BOOT][7:0];
    assign temp_x100 = 15'(temp_c_in) * 15'd100;
    assign add_limit = 15'(power_cfg_pkg::tmax_decode(mem_r[power_cfg_pkg::IDX_TLIM_ISCALE][2:0])) * 15'(add_pct);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hf_gain_x2_out    <= 1'b0;
            noload_trim_q_out <= 6'sh00;
            readback_ofs_out  <= 4'sh0;
            iout_reading_out  <= 8'h00;
            boot_mv_out       <= 12'h000;
        end else if (ce_in) begin
            hf_gain_x2_out <= mem_r[power_cfg_pkg::IDX_MOD_CFG][power_cfg_pkg::HF_GAIN_BIT];
            // sign-magnitude, negative side offset by one step: 10h is -0.25
            if (mem_r[power_cfg_pkg::IDX_DROOP_TRIM][4])
                noload_trim_q_out <= -$signed({2'b00, mem_r[power_cfg_pkg::IDX_DROOP_TRIM][3:0]}) - 6'sh01;
            else
                noload_trim_q_out <= $signed({2'b00, mem_r[power_cfg_pkg::IDX_DROOP_TRIM][3:0]});
            readback_ofs_out <= power_cfg_pkg::sext3(ofs_field);
            if (iout_sum < 0)
                iout_reading_out <= 8'h00;
            else if (iout_sum > 10'sh0ff)
                iout_reading_out <= 8'hff;
            else
                iout_reading_out <= iout_sum[7:0];
            if (boot_code == 8'h00)
                boot_mv_out <= 12'h000;
            else if (vid_res_5mv_in)
                boot_mv_out <= power_cfg_pkg::BOOT_BASE_5 + 12'(boot_code - 8'h01) * power_cfg_pkg::BOOT_STEP_5;
            else
                boot_mv_out <= power_cfg_pkg::BOOT_BASE_10 + 12'(boot_code - 8'h01) * power_cfg_pkg::BOOT_STEP_10;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            iin_full_scale_a_out  <= 5'h1f;
            tcomp_enable_out      <= 1'b0;
            tcomp_offset_dc_out   <= 10'sh000;
            thermal_phase_add_out <= 1'b0;
        end else if (ce_in) begin
            case (mem_r[power_cfg_pkg::IDX_TLIM_ISCALE][5:3])
                3'h1:    iin_full_scale_a_out <= 5'h0f;
                3'h2:    iin_full_scale_a_out <= 5'h07;
                3'h3:    iin_full_scale_a_out <= 5'h03;
                3'h4:    iin_full_scale_a_out <= 5'h01;
                // undefined codes fall back to the widest range
                default: iin_full_scale_a_out <= 5'h1f;
            endcase
            tcomp_enable_out <= (mem_r[power_cfg_pkg::IDX_TCOMP_ADD][3:0] != 4'h0);
            case (mem_r[power_cfg_pkg::IDX_TCOMP_ADD][3:0])
                4'h1:    tcomp_offset_dc_out <= -10'sd25;
                4'h2:    tcomp_offset_dc_out <= 10'sd0;
                4'h3:    tcomp_offset_dc_out <= 10'sd25;
                4'h4:    tcomp_offset_dc_out <= 10'sd50;
                4'h5:    tcomp_offset_dc_out <= 10'sd70;
                4'h6:    tcomp_offset_dc_out <= 10'sd100;
                4'h7:    tcomp_offset_dc_out <= 10'sd130;
                4'h8:    tcomp_offset_dc_out <= 10'sd160;
                4'h9:    tcomp_offset_dc_out <= 10'sd189;
                4'ha:    tcomp_offset_dc_out <= 10'sd216;
                4'hb:    tcomp_offset_dc_out <= 10'sd243;
                4'hc:    tcomp_offset_dc_out <= 10'sd270;
                4'hd:    tcomp_offset_dc_out <= 10'sd297;
                4'he:    tcomp_offset_dc_out <= 10'sd324;
                4'hf:    tcomp_offset_dc_out <= 10'sd351;
                default: tcomp_offset_dc_out <= 10'sd0;
            endcase
            // compared in hundredths to avoid a divider
            thermal_phase_add_out <= (temp_x100 >= add_limit);
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            freq_limiter_en_out <= 1'b1;
            speedup_pf_out      <= 5'h00;
            deadband_mv_out     <= 8'h00;
            k_factor_q_out      <= 2'h0;
            k_active_out        <= 1'b0;
        end else if (ce_in) begin
            freq_limiter_en_out <= (mem_r[power_cfg_pkg::IDX_SPEEDUP][2:0] == 3'h0);
            case (mem_r[power_cfg_pkg::IDX_SPEEDUP][2:0])
                3'h7:    speedup_pf_out <= 5'h10;
                default: speedup_pf_out <= {1'b0, mem_r[power_cfg_pkg::IDX_SPEEDUP][2:0], 1'b0};
            endcase
            deadband_mv_out <= 8'({5'h00, mem_r[power_cfg_pkg::IDX_SPEEDUP][5:3]} + 8'h01)
                             * power_cfg_pkg::DBAND_STEP_MV;
            k_factor_q_out  <= mem_r[power_cfg_pkg::IDX_SPEEDUP][7:6];
            k_active_out    <= !(disc_conduction_in && mem_r[power_cfg_pkg::IDX_SPEEDUP][power_cfg_pkg::K_DISC_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_host_write_refused;
        ce_in && host_write_busy && !host_rd_in;
    endsequence
    sequence s_refused_answer;
        host_err_out && !host_ack_out;
    endsequence
    sequence s_reload_taken;
        ce_in && reload_in && !ld.busy;
    endsequence

    chk_gain_decode: assert property (ce_in |=> hf_gain_x2_out == $past(mem_r[0][13]))
        else $error("balance gain bit not decoded");
    chk_trim_sign: assert property (ce_in && mem_r[1][4] |=> noload_trim_q_out < 0)
        else $error("negative trim code gave non-negative offset");
    chk_offset_two_phase: assert property (ce_in && phase_count_in == 3'h2
        |=> readback_ofs_out == power_cfg_pkg::sext3($past(mem_r[2][5:3])))
        else $error("two-phase readback offset not selected");
    chk_boot_zero: assert property (ce_in && mem_r[3][7:0] == 8'h00 |=> boot_mv_out == 12'h000)
        else $error("boot code zero not reported as zero");
    chk_boot_readback: assert property (ce_in && host_rd_in && host_cmd_in == power_cfg_pkg::CODE_BOOT
        |=> host_ack_out && host_rdata_out == $past(mem_r[3]))
        else $error("boot register read does not return stored code");
    chk_iin_default: assert property (ce_in && mem_r[5][5:3] == 3'h0 |=> iin_full_scale_a_out == 5'h1f)
        else $error("input full scale code zero not 31 A");
    chk_tcomp_off: assert property (ce_in && mem_r[6][3:0] == 4'h0 |=> !tcomp_enable_out)
        else $error("thermal compensation active at code zero");
    chk_phase_add_full: assert property (ce_in && mem_r[6][5:4] == 2'h3
        && temp_c_in >= 8'(power_cfg_pkg::tmax_decode(mem_r[5][2:0])) |=> thermal_phase_add_out)
        else $error("phase add missed at full thermal limit");
    chk_limiter_off: assert property (ce_in && mem_r[8][2:0] != 3'h0 |=> !freq_limiter_en_out)
        else $error("frequency limiter left on with speed-up");
    chk_deadband: assert property (ce_in && mem_r[8][5:3] == 3'h7 |=> deadband_mv_out == 8'hc8)
        else $error("dead band top code not 200 mV");
    chk_k_disc: assert property (ce_in && disc_conduction_in && mem_r[8][8] |=> !k_active_out)
        else $error("k-factor active in discontinuous conduction");
    chk_write_refused: assert property (s_host_write_refused |=> s_refused_answer)
        else $error("host write during load not refused");
    chk_reload_busy: assert property (s_reload_taken ##1 ce_in |=> load_busy_out)
        else $error("reload did not start loading");

endmodule

//--- tb/host_model.sv
module host_model (
    input  wire logic        clock_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        ack_in,
    input  wire logic        err_in,
    output logic      [7:0]  cmd_out,
    output logic      [15:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rdat;
    logic [1:0]  resp;
    initial {cmd_out, wdata_out, wr_out, rd_out} = '0;
    // resp stays 0 when nothing answers within three cycles
    task automatic access(input logic rd, input logic [7:0] cmd, input logic [15:0] wd);
        @(negedge clock_in);
        {cmd_out, wdata_out, rd_out, wr_out} = {cmd, wd, rd, ~rd};
        @(negedge clock_in);
        // released cmd and data lines flip so stale values never look fresh
        {cmd_out, wdata_out, rd_out, wr_out} = {~cmd, ~wd, 2'b00};
        resp = 2'b00;
        for (int i = 0; i < 3 && resp == 2'b00; i++) begin
            if (ack_in === 1'b1 || err_in === 1'b1) begin
                resp = {err_in, ack_in};
                rdat = rdata_in;
            end else begin
                @(negedge clock_in);
            end
        end
    endtask
endmodule

//--- tb/power_config_register_bank_tb_top.sv
module power_config_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, reload_in = 1'b0, disc_conduction_in = 1'b0;
    logic              host_wr_in, host_rd_in, vid_res_5mv_in = 1'b0, host_ack_out, host_err_out;
    logic              load_busy_out, hf_gain_x2_out, tcomp_enable_out, thermal_phase_add_out;
    logic              freq_limiter_en_out, k_active_out;
    logic        [7:0] host_cmd_in, temp_c_in = 8'h00, boot_strap_code_in = 8'h5a, iout_reading_out;
    logic        [7:0] deadband_mv_out;
    logic       [15:0] host_wdata_in, host_rdata_out, nvm_data_in = 16'h0000;
    logic        [2:0] phase_count_in = 3'h1;
    logic        [9:0] monitor_level_in = 10'h200;
    logic        [3:0] nvm_index_out, last_idx = 4'h0;
    logic signed [5:0] noload_trim_q_out;
    logic signed [3:0] readback_ofs_out;
    logic signed [9:0] tcomp_offset_dc_out;
    logic       [11:0] boot_mv_out;
    logic        [4:0] iin_full_scale_a_out, speedup_pf_out;
    logic        [1:0] k_factor_q_out;
    int                err_count = 0, compares = 0;
    power_config_register_bank #(.ADC_W(10)) DUT (.*);
    host_model host (.clock_in, .rdata_in(host_rdata_out), .ack_in(host_ack_out), .err_in(host_err_out),
        .cmd_out(host_cmd_in), .wdata_out(host_wdata_in), .wr_out(host_wr_in), .rd_out(host_rd_in));
    always #12.5 clock_in = ~clock_in;
    // nvm answers one cycle after the index is shown
    always @(negedge clock_in) {nvm_data_in, last_idx} <= {16'hc35a ^ {4{last_idx}}, nvm_index_out};
    ////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic rd, input logic [7:0] c, input logic [15:0] d, input logic [1:0] e);
        host.access(rd, c, d);
        if (host.resp == 2'b00) begin
            err_count++;
            wrap_up();
        end
        chk("answer", 16'(e), 16'(host.resp));
        repeat (3) @(negedge clock_in);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        acc(1'b0, c, d, 2'b01);
    endtask
    task automatic wait_idle();
        repeat (2) @(negedge clock_in);
        for (int i = 0; load_busy_out !== 1'b0; i++) begin
            if (i == 40) begin
                err_count++;
                wrap_up();
            end
            @(negedge clock_in);
        end
    endtask
    task automatic t_load();
        logic [7:0] cd [9] = '{8'he3, 8'he4, 8'he5, 8'he6, 8'he7, 8'he8, 8'he9, 8'hea, 8'hf3};
        wait_idle();
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, cd[i], 16'h0000, 2'b01);
            chk("load", (16'hc35a ^ {4{4'(i)}}) & power_cfg_pkg::REG_MASK[i], host.rdat);
        end
        acc(1'b1, 8'h00, 16'h0000, 2'b10);
        acc(1'b1, 8'hd0, 16'h0000, 2'b01);
        chk("strap", 16'h005a, host.rdat);
        reload_in = 1'b1;
        @(negedge clock_in) reload_in = 1'b0;
        acc(1'b0, 8'he4, 16'h0155, 2'b10);
        wait_idle();
        wr(8'he4, 16'h0155);
        acc(1'b1, 8'he4, 16'h0000, 2'b01);
        chk("override", 16'h0155, host.rdat);
        reload_in = 1'b1;
        @(negedge clock_in) reload_in = 1'b0;
        wait_idle();
        acc(1'b1, 8'he4, 16'h0000, 2'b01);
        chk("reload", 16'h024b, host.rdat);
    endtask
    task automatic t_fields();
        logic signed [5:0] tq [4] = '{6'sh01, -6'sh01, -6'sh10, 6'sh0f};
        logic [4:0] tc [4] = '{5'h01, 5'h10, 5'h1f, 5'h0f};
        logic signed [3:0] of [3] = '{4'sh3, -4'sh4, -4'sh1};
        logic [11:0] bm [6] = '{12'h000, 12'h000, 12'h1f4, 12'h0fa, 12'hbe0, 12'h5f0};
        logic [4:0] ia [5] = '{5'h1f, 5'h0f, 5'h07, 5'h03, 5'h01};
        logic [4:0] pf [8] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h10};
        logic [7:0] bc [3] = '{8'h00, 8'h01, 8'hff};
        wr(8'he3, 16'h2000);
        chk("gain", 16'h0001, 16'(hf_gain_x2_out));
        for (int i = 0; i < 4; i++) begin
            wr(8'he4, 16'(tc[i]));
            chk("trim", 16'(tq[i]), 16'(noload_trim_q_out));
        end
        wr(8'he5, 16'h01e3);
        wr(8'hea, 16'h00c8);
        for (int i = 0; i < 3; i++) begin
            phase_count_in = 3'(i + 1);
            repeat (3) @(negedge clock_in);
            chk("ofs", 16'(of[i]), 16'(readback_ofs_out));
            chk("iout", 16'(100 + int'(of[i])), 16'(iout_reading_out));
        end
        for (int i = 0; i < 6; i++) begin
            vid_res_5mv_in = i[0];
            wr(8'he6, {8'h00, bc[i / 2]});
            chk("boot", 16'(bm[i]), 16'(boot_mv_out));
        end
        for (int i = 0; i < 5; i++) begin
            wr(8'he8, 16'(i * 8));
            chk("iin", 16'(ia[i]), 16'(iin_full_scale_a_out));
        end
        temp_c_in = 8'h4b;
        wr(8'he9, 16'h000f);
        chk("tcomp", 16'h015f, 16'(tcomp_offset_dc_out));
        chk("tcomp_on", 16'h0001, 16'(tcomp_enable_out));
        chk("add", 16'h0001, 16'(thermal_phase_add_out));
        wr(8'he9, 16'h0030);
        chk("tcomp_on", 16'h0000, 16'(tcomp_enable_out));
        chk("add", 16'h0000, 16'(thermal_phase_add_out));
        temp_c_in = 8'h64;
        repeat (3) @(negedge clock_in);
        chk("add_full", 16'h0001, 16'(thermal_phase_add_out));
        for (int c = 0; c < 8; c++) begin
            wr(8'hf3, 16'({c[1:0], c[2:0], c[2:0]}));
            chk("pf", 16'(pf[c]), 16'(speedup_pf_out));
            chk("limiter", 16'(c == 0), 16'(freq_limiter_en_out));
            chk("dband", 16'(25 * (c + 1)), 16'(deadband_mv_out));
            chk("k", 16'(c % 4), 16'(k_factor_q_out));
        end
        disc_conduction_in = 1'b1;
        wr(8'hf3, 16'h0100);
        chk("k_active", 16'h0000, 16'(k_active_out));
    endtask
    initial begin
        repeat (3) @(negedge clock_in);
        rst_b_in = 1'b1;
        t_load();
        t_fields();
        wrap_up();
    end
endmodule
